// file: rtl/bss_pkg.sv
package bss_pkg;
  // isp control register map
  localparam logic [7:0] ISP_CTRL_ADDR   = 8'hBF;
  localparam logic [7:0] ISP_CTRL_RESET  = 8'h00;
  localparam int         BOOT_MODE_BIT   = 7;
  localparam int         REBOOT_BIT      = 7;
  localparam int         AUX_RAM_BIT     = 4;
  localparam int         LOC_SEL_BIT     = 1;
  localparam int         PROG_EN_BIT     = 0;
  localparam logic [7:0] ISP_CTRL_WMASK  = 8'h13;
  // port-2 strap bit positions
  localparam int         STRAP_HI_BIT    = 7;
  localparam int         STRAP_LO_BIT    = 6;
  // fetch base addresses
  localparam logic [15:0] MAIN_ROM_BASE  = 16'h0000;
  localparam logic [15:0] LOADER_BASE    = 16'h0000;
  // cycles the reboot request is held as an internal reset
  localparam logic [3:0] REBOOT_HOLD     = 4'h4;
  typedef enum logic {BOOT_MAIN, BOOT_LOADER} bss_src_type;
endpackage

// file: rtl/bss_strap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bss_strap_if;
  logic forceReq;
  logic sampleEn;
  modport decoder (output forceReq, input sampleEn);
  modport top     (input forceReq, output sampleEn);
endinterface
`default_nettype wire

// file: rtl/bss_strap_decode.sv
`timescale 1ns/1ps
`default_nettype none
module bss_strap_decode (
  input  wire logic        bootForcePin,
  input  wire logic [7:0]  port2In,
  bss_strap_if.decoder     sif
);
  // forcing when pin low, or both port-2 strap bits low
  always_comb begin
    sif.forceReq = !bootForcePin ||
      (!port2In[bss_pkg::STRAP_HI_BIT] &&
       !port2In[bss_pkg::STRAP_LO_BIT]);
  end
endmodule
`default_nettype wire

// file: rtl/bss_boot_select.sv
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// - no strap, boot from main program rom
// - pin low or both p2.7 and p2.6 low forces loader
// - forced loader boot fetches from loader rom
// - selection held after straps released
// - control bit 7 reads 1 in forced boot
// - reboot bit with both enables resets device
module bss_boot_select (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        bootForcePin,
  input  wire logic [7:0]  port2In,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic [7:0]       regRdData,
  output logic             loaderBoot,
  output logic [15:0]      fetchBase,
  output logic             coreResetn,
  output logic             auxRamEn,
  output logic             romProgEn,
  output logic             loaderLocSel
);
  ////////////////////////////////////////////////////////////////////////
  bss_strap_if sif ();

  bss_strap_decode u_dec (
    .bootForcePin (bootForcePin),
    .port2In      (port2In),
    .sif          (sif)
  );

  ////////////////////////////////////////////////////////////////////////
  // internal reset: pin reset or software reboot
  logic [3:0]               reboot_ff, nxt_reboot;
  logic                     inReset;
  logic                     rebootReq;
  logic                     ctrlWr;

  assign ctrlWr    = regWrStb && (regAddr == bss_pkg::ISP_CTRL_ADDR);
  assign rebootReq = ctrlWr && regWrData[bss_pkg::REBOOT_BIT] &&
                     loaderLocSel && romProgEn;
  assign inReset   = !resetn || (reboot_ff != 4'h0);
  assign sif.sampleEn = inReset;

  // reboot hold counter
  always_comb begin
    nxt_reboot = reboot_ff;
    if (rebootReq) begin
      nxt_reboot = bss_pkg::REBOOT_HOLD;
    end else if (reboot_ff != 4'h0) begin
      nxt_reboot = reboot_ff - 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reboot_ff <= 4'h0;
    end else begin
      reboot_ff <= nxt_reboot;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap sampling and boot source latch
  bss_pkg::bss_src_type     src_ff, nxt_src;
  logic                     coreRst_ff, nxt_coreRst;

  always_comb begin
    nxt_src = src_ff;
    if (inReset) begin
      nxt_src = sif.forceReq ? bss_pkg::BOOT_LOADER
                             : bss_pkg::BOOT_MAIN;
    end
    nxt_coreRst = !inReset;
  end

  // selection frozen once reset released
  always_ff @(posedge ref_clk) begin
    src_ff     <= nxt_src;
    coreRst_ff <= nxt_coreRst;
  end

  ////////////////////////////////////////////////////////////////////////
  // control register
  logic [7:0]               ctrl_ff, nxt_ctrl;
  logic [7:0]               rd_ff, nxt_rd;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (inReset) begin
      nxt_ctrl = bss_pkg::ISP_CTRL_RESET;
    end else if (ctrlWr) begin
      nxt_ctrl = regWrData & bss_pkg::ISP_CTRL_WMASK;
    end
    nxt_rd = 8'h00;
    if (regRdStb && regAddr == bss_pkg::ISP_CTRL_ADDR) begin
      nxt_rd = ctrl_ff;
      nxt_rd[bss_pkg::BOOT_MODE_BIT] =
        (src_ff == bss_pkg::BOOT_LOADER);
    end
  end

  always_ff @(posedge ref_clk) begin
    ctrl_ff <= nxt_ctrl;
    if (!resetn) begin
      rd_ff <= 8'h00;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      loaderBoot   <= 1'b0;
      fetchBase    <= bss_pkg::MAIN_ROM_BASE;
      auxRamEn     <= 1'b0;
      romProgEn    <= 1'b0;
      loaderLocSel <= 1'b0;
    end else begin
      loaderBoot   <= (nxt_src == bss_pkg::BOOT_LOADER);
      fetchBase    <= (nxt_src == bss_pkg::BOOT_LOADER) ?
                      bss_pkg::LOADER_BASE :
                      bss_pkg::MAIN_ROM_BASE;
      auxRamEn     <= nxt_ctrl[bss_pkg::AUX_RAM_BIT];
      romProgEn    <= nxt_ctrl[bss_pkg::PROG_EN_BIT];
      loaderLocSel <= nxt_ctrl[bss_pkg::LOC_SEL_BIT];
    end
  end

  assign regRdData  = rd_ff;
  assign coreResetn = coreRst_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // output shows the latch one edge after the first released edge
  a_strap_latch: assert property (@(posedge ref_clk)
    (!resetn ##1 resetn) |=> loaderBoot == $past(sif.forceReq, 2))
    else $error("boot source not latched at release");

  // first released edge still moves the output, so look two back
  a_select_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!inReset && $past(!inReset) && $past(!inReset, 2)) |->
    $stable(loaderBoot))
    else $error("boot source changed outside reset");

  a_main_default: assert property (@(posedge ref_clk)
    ($past(!resetn) && resetn && !$past(sif.forceReq)) |=>
    fetchBase == bss_pkg::MAIN_ROM_BASE && !loaderBoot)
    else $error("main rom not selected");

  a_mode_readback: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (regRdStb && regAddr == bss_pkg::ISP_CTRL_ADDR) |=>
    regRdData[7] == loaderBoot)
    else $error("mode bit readback wrong");

  a_reboot_reset: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    rebootReq |-> ##2 !coreResetn [*4])
    else $error("reboot did not reset core");

  a_loader_fetch: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    loaderBoot |-> fetchBase == bss_pkg::LOADER_BASE)
    else $error("loader fetch base wrong");

  a_no_reboot: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ctrlWr && !(loaderLocSel && romProgEn) && reboot_ff == 4'h0)
    |=> reboot_ff == 4'h0)
    else $error("reboot without enables");

  a_strap_decode: assert property (@(posedge ref_clk)
    sif.forceReq == (!bootForcePin || port2In[7:6] == 2'b00))
    else $error("strap decode wrong");

  // pin reset puts the boot, fetch, core reset and read data outputs in their idle state
  a_reset_outputs: assert property (@(posedge ref_clk)
    !resetn |=> !loaderBoot && !coreResetn && regRdData == 8'h00 &&
    fetchBase == bss_pkg::MAIN_ROM_BASE)
    else $error("outputs not idle after reset");

  // straps followed on every edge while reset is active
  a_sample_reset: assert property (@(posedge ref_clk)
    inReset |=> (src_ff == bss_pkg::BOOT_LOADER) == $past(sif.forceReq))
    else $error("straps not sampled in reset");

  // core held in reset for pin reset and reboot alike
  a_core_held: assert property (@(posedge ref_clk)
    inReset |=> !coreResetn)
    else $error("core not held in reset");

  // control bits cleared as on power-on
  a_ctrl_cleared: assert property (@(posedge ref_clk)
    inReset |=> ctrl_ff == bss_pkg::ISP_CTRL_RESET)
    else $error("control not cleared in reset");

  // reboot request loads the hold counter
  a_reboot_start: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    rebootReq |=> reboot_ff == bss_pkg::REBOOT_HOLD)
    else $error("reboot hold not started");

  // straps resampled during a software reboot
  a_reboot_resample: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (reboot_ff != 4'h0 && sif.forceReq) |=> loaderBoot)
    else $error("reboot did not resample straps");

  // only the writable bits reach the enables
  a_write_mask: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ctrlWr && !inReset) |=>
    {auxRamEn, loaderLocSel, romProgEn} ==
    $past({regWrData[bss_pkg::AUX_RAM_BIT],
           regWrData[bss_pkg::LOC_SEL_BIT],
           regWrData[bss_pkg::PROG_EN_BIT]}))
    else $error("control write wrong");

  // read data zero unless the control register was read
  a_read_idle: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    !(regRdStb && regAddr == bss_pkg::ISP_CTRL_ADDR) |=>
    regRdData == 8'h00)
    else $error("read data not zero");
endmodule
`default_nettype wire

// file: test/bss_strap_model.sv
`timescale 1ns/1ps
`default_nettype none
// board switches on the strap pins, pull-ups keep them high
module bss_strap_model (
  input  wire logic [1:0] pressed,
  input  wire logic [5:0] otherBits,
  output logic            bootForcePin,
  output logic [7:0]      port2In
);
  // 0 idle, 1 pin low, 2 both port-2 straps low, 3 only bit 6 low
  assign bootForcePin = (pressed != 2'h1);
  assign port2In = {pressed != 2'h2, pressed < 2'h2, otherBits};
endmodule
`default_nettype wire

// file: test/boot_source_strap_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module boot_source_strap_select_tb_top;
  logic ref_clk, resetn, regWrStb, regRdStb, lbExp;
  logic rdSeen = 1'b0;
  logic loaderBoot, coreResetn, auxRamEn, romProgEn, loaderLocSel;
  logic bootForcePin;
  logic [1:0]  pressed;
  logic [5:0]  otherBits;
  logic [7:0]  regAddr, regWrData, regRdData, port2In;
  logic [15:0] fetchBase;
  logic [7:0]  rdQ[$];
  int          errors, nCompared;
  bss_strap_model i_bss_strap_model (.pressed(pressed),
    .otherBits(otherBits), .bootForcePin(bootForcePin), .port2In(port2In));
  bss_boot_select i_bss_boot_select (.ref_clk(ref_clk), .resetn(resetn),
    .bootForcePin(bootForcePin), .port2In(port2In), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .loaderBoot(loaderBoot), .fetchBase(fetchBase),
    .coreResetn(coreResetn), .auxRamEn(auxRamEn), .romProgEn(romProgEn),
    .loaderLocSel(loaderLocSel));
  ////////////////////////////////////////////////////////////////////////
  // clock and result checking
  always #25 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d compared %0d", errors, nCompared);
    if (errors == 0 && nCompared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // read data checked in the cycle after each read strobe
  always @(posedge ref_clk) begin
    rdSeen <= regRdStb;
  end
  // mid-cycle, while the read data stand
  always @(negedge ref_clk) begin
    if (rdSeen) chk({8'h00, regRdData}, {8'h00, rdQ.pop_front()});
  end
  ////////////////////////////////////////////////////////////////////////
  // bus and sequencing tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a; regWrData <= d; regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a; regRdStb <= 1'b1; rdQ.push_back(exp);
    @(posedge ref_clk);
    regRdStb <= 1'b0;
  endtask
  task automatic waitRst(input logic lvl);
    int i;
    for (i = 0; i < 20 && coreResetn !== lvl; i++) @(posedge ref_clk);
    if (i == 20) begin
      errors++;
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // stimulus
  initial begin
    ref_clk = 0; resetn = 0; regWrStb = 0; regRdStb = 0;
    regAddr = 0; regWrData = 0; pressed = 0; otherBits = 0;
    errors = 0; nCompared = 0;
    void'($urandom(94));
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk);
      pressed <= m[1:0]; otherBits <= 6'($urandom); resetn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      pressed <= 2'h0;
      lbExp = (m == 1 || m == 2);
      repeat (3) @(posedge ref_clk);
      chk({15'h0000, loaderBoot}, {15'h0000, lbExp});
      chk(fetchBase, lbExp ? bss_pkg::LOADER_BASE
                           : bss_pkg::MAIN_ROM_BASE);
      chk({15'h0000, coreResetn}, 16'h0001);
      rd(bss_pkg::ISP_CTRL_ADDR, {lbExp, 7'h00});
      wr(bss_pkg::ISP_CTRL_ADDR, 8'h80);
      wr(8'($urandom_range(0, 8'hBE)), 8'($urandom));
      rd(8'($urandom_range(0, 8'hBE)), 8'h00);
      wr(bss_pkg::ISP_CTRL_ADDR, 8'hFF);
      rd(bss_pkg::ISP_CTRL_ADDR, {lbExp, 7'h13});
      @(posedge ref_clk);
      chk({13'h0, auxRamEn, loaderLocSel, romProgEn}, 16'h0007);
      chk({15'h0000, coreResetn}, 16'h0001);
      pressed <= 2'h1;
      wr(bss_pkg::ISP_CTRL_ADDR, 8'h80);
      waitRst(1'b0);
      waitRst(1'b1);
      pressed <= 2'h0;
      rd(bss_pkg::ISP_CTRL_ADDR, 8'h80);
      repeat (2) @(posedge ref_clk);
    end
    complete_run();
  end
endmodule
`default_nettype wire
